// ### logic/ttc_core.sv
/*
 * Thermometer/thermostat core: 3-wire serial slave, conversion timer
 * and the three trip outputs.
 * Assumes the serial pins are asynchronous to clk_sys and that
 * sensor_code is a synchronous reading from the sensing front end.
 */
`timescale 1ns/1ps
`default_nettype none
module ttc_core #(
	parameter int CONVERT_TRIGGER_CYC = ttc_pkg::CONVERT_TRIGGER_CYCLES // Shorten in simulation
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce, // Low freezes all state
	input wire logic clock_convert_pin, // Serial clock or convert trigger
	input wire logic port_reset_pin, // High while a transfer is open
	input wire logic data_pin_sample, // Level seen on the data wire
	output logic data_pin_drive, // Level we drive on the data wire
	output logic data_pin_oe_n, // Low while we drive the data wire
	input wire logic [8:0] sensor_code, // Raw reading, half-degree steps
	output logic high_trip_out,
	output logic low_trip_out,
	output logic hysteresis_trip_out,
	output logic convert_trigger_busy // High while a conversion runs
);

	////////////////////////////////////////////////////////////////////
	// Functions

	// Word returned by a read command
	function automatic logic [8:0] ttc_read_word(input logic [7:0] cmd, input logic [8:0] t,
		input logic [8:0] up, input logic [8:0] lo);
		case (cmd)
			ttc_pkg::CMD_RD_TEMP: ttc_read_word = t;
			ttc_pkg::CMD_RD_UPPER: ttc_read_word = up;
			default: ttc_read_word = lo;
		endcase
	endfunction : ttc_read_word

	// Clamp a reading into the measurable range
	function automatic logic [8:0] ttc_clamp(input logic [8:0] v);
		if ($signed(v) < $signed(ttc_pkg::TEMP_MIN))
			ttc_clamp = ttc_pkg::TEMP_MIN;
		else if ($signed(v) > $signed(ttc_pkg::TEMP_MAX))
			ttc_clamp = ttc_pkg::TEMP_MAX;
		else
			ttc_clamp = v;
	endfunction : ttc_clamp

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge finders

	logic [2:0] s1_q, s1_d; // First stage {reset, clock, data}
	logic [2:0] s2_q, s2_d; // Second stage
	logic [1:0] prev_q, prev_d; // Previous {reset, clock}
	logic pe_s, clk_s, dq_s, clk_rise, clk_fall, pe_fall;

	// Next values of the synchronisers
	always_comb
	begin
		s1_d = {port_reset_pin, clock_convert_pin, data_pin_sample};
		s2_d = s1_q;
		prev_d = s2_q[2:1];
	end

	// Registers of the synchronisers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s1_q <= 3'h2; // Idle clock high, port closed
			s2_q <= 3'h2;
			prev_q <= 2'h1;
		end
		else if (ce)
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			prev_q <= prev_d;
		end
	end

	assign pe_s = s2_q[2];
	assign clk_s = s2_q[1];
	assign dq_s = s2_q[0];
	assign clk_rise = clk_s & ~prev_q[0];
	assign clk_fall = ~clk_s & prev_q[0];
	assign pe_fall = ~pe_s & prev_q[1];

	////////////////////////////////////////////////////////////////////
	// Serial port

	ttc_pkg::ttc_port_t st_q, st_d;
	logic [4:0] bcnt_q, bcnt_d; // Bits seen in the current phase
	logic [7:0] cmd_q, cmd_d; // Command, shifted in LSB first
	logic [7:0] cmd_new;
	logic [8:0] sh_q, sh_d; // Read shifter, zero fill at the top
	logic [8:0] wr_q, wr_d; // Write data gathered bit by bit
	logic [8:0] upper_q, upper_d; // upper_trip_point
	logic [8:0] lower_q, lower_d; // lower_trip_point
	logic [8:0] temp_q; // measured_temperature
	logic dq_q, dq_d, oe_n_q, oe_n_d;
	logic convert_trigger_cmd, commit;

	// Next values of the serial port
	always_comb
	begin
		st_d = st_q;
		bcnt_d = bcnt_q;
		cmd_d = cmd_q;
		sh_d = sh_q;
		wr_d = wr_q;
		upper_d = upper_q;
		lower_d = lower_q;
		dq_d = dq_q;
		oe_n_d = oe_n_q;
		convert_trigger_cmd = 1'b0;
		commit = 1'b0;
		cmd_new = {dq_s, cmd_q[7:1]};
		if (!pe_s)
		begin
			// Port closed: release the wire and rearm
			st_d = ttc_pkg::S_CMD;
			bcnt_d = '0;
			oe_n_d = 1'b1;
			// Nine or more bits commit; extra bits were dropped
			if (pe_fall && st_q == ttc_pkg::S_WRITE && bcnt_q >= 5'h09)
			begin
				commit = 1'b1;
				if (cmd_q == ttc_pkg::CMD_WR_UPPER)
					upper_d = wr_q;
				else
					lower_d = wr_q;
			end
		end
		else
		begin
			if (clk_rise)
			begin
				// Rising edge samples input and ends our drive
				oe_n_d = 1'b1;
				case (st_q)
					ttc_pkg::S_CMD:
					begin
						cmd_d = cmd_new;
						bcnt_d = bcnt_q + 5'h01;
						if (bcnt_q == 5'h07)
						begin
							bcnt_d = '0;
							case (cmd_new)
								ttc_pkg::CMD_RD_TEMP, ttc_pkg::CMD_RD_UPPER, ttc_pkg::CMD_RD_LOWER:
								begin
									st_d = ttc_pkg::S_READ;
									sh_d = ttc_read_word(cmd_new, temp_q, upper_q, lower_q);
								end
								ttc_pkg::CMD_WR_UPPER, ttc_pkg::CMD_WR_LOWER:
									st_d = ttc_pkg::S_WRITE;
								ttc_pkg::CMD_CONVERT:
								begin
									convert_trigger_cmd = 1'b1;
									st_d = ttc_pkg::S_IGNORE;
								end
								default:
									st_d = ttc_pkg::S_IGNORE; // Unknown command
							endcase
						end
					end
					ttc_pkg::S_WRITE:
					begin
						// Only the first nine data bits count
						if (bcnt_q < 5'h09)
							wr_d[bcnt_q[3:0]] = dq_s;
						if (bcnt_q != ttc_pkg::BCNT_MAX)
							bcnt_d = bcnt_q + 5'h01;
					end
					default:
					begin
					end
				endcase
			end
			if (clk_fall && st_q == ttc_pkg::S_READ)
			begin
				// Falling edge puts out the next bit, zeros after the top
				dq_d = sh_q[0];
				sh_d = {1'b0, sh_q[8:1]};
				oe_n_d = 1'b0;
			end
		end
	end

	// Registers of the serial port
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_q <= ttc_pkg::S_CMD;
			bcnt_q <= '0;
			cmd_q <= '0;
			sh_q <= '0;
			wr_q <= '0;
			upper_q <= ttc_pkg::UPPER_FACTORY;
			lower_q <= ttc_pkg::LOWER_FACTORY;
			dq_q <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else if (ce)
		begin
			st_q <= st_d;
			bcnt_q <= bcnt_d;
			cmd_q <= cmd_d;
			sh_q <= sh_d;
			wr_q <= wr_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			dq_q <= dq_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign data_pin_drive = dq_q;
	assign data_pin_oe_n = oe_n_q;

	////////////////////////////////////////////////////////////////////
	// Conversion and thermostat

	ttc_pkg::ttc_convert_trigger_t cs_q, cs_d;
	logic [27:0] cnt_q, cnt_d; // Cycles into the conversion
	logic [8:0] temp_d, new_t;
	logic hi_q, hi_d, lo_q, lo_d, com_q, com_d;
	logic convert_trigger_start, convert_trigger_done;

	// Next values of conversion and trip outputs
	always_comb
	begin
		cs_d = cs_q;
		cnt_d = cnt_q;
		temp_d = temp_q;
		hi_d = hi_q;
		lo_d = lo_q;
		com_d = com_q;
		new_t = ttc_clamp(sensor_code);
		// Pin held low keeps converting when the port is closed
		convert_trigger_start = convert_trigger_cmd | (~pe_s & clk_fall) | (~pe_s & ~clk_s);
		convert_trigger_done = 1'b0;
		case (cs_q)
			ttc_pkg::C_IDLE:
			begin
				if (convert_trigger_start)
				begin
					cs_d = ttc_pkg::C_BUSY;
					cnt_d = '0;
				end
			end
			ttc_pkg::C_BUSY:
			begin
				if (cnt_q >= CONVERT_TRIGGER_CYC[27:0] - 28'h0000001)
				begin
					// End of conversion: new word and fresh comparisons
					convert_trigger_done = 1'b1;
					cs_d = ttc_pkg::C_IDLE;
					temp_d = new_t;
					hi_d = $signed(new_t) >= $signed(upper_q);
					lo_d = $signed(new_t) <= $signed(lower_q);
					if ($signed(new_t) >= $signed(upper_q))
						com_d = 1'b1;
					else if ($signed(new_t) < $signed(lower_q))
						com_d = 1'b0;
				end
				else
					cnt_d = cnt_q + 28'h0000001;
			end
			default:
				cs_d = ttc_pkg::C_IDLE;
		endcase
	end

	// Registers of conversion and trip outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cs_q <= ttc_pkg::C_IDLE;
			cnt_q <= '0;
			temp_q <= ttc_pkg::TEMP_POR;
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			com_q <= 1'b0;
		end
		else if (ce)
		begin
			cs_q <= cs_d;
			cnt_q <= cnt_d;
			temp_q <= temp_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			com_q <= com_d;
		end
	end

	assign high_trip_out = hi_q;
	assign low_trip_out = lo_q;
	assign hysteresis_trip_out = com_q;
	assign convert_trigger_busy = (cs_q == ttc_pkg::C_BUSY);

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_high_trip: assert property (ce && convert_trigger_done && !commit |=> high_trip_out == ($signed(temp_q) >= $signed(upper_q)))
		else $error("high trip disagrees with compare");
	a_low_trip: assert property (ce && convert_trigger_done && !commit |=> low_trip_out == ($signed(temp_q) <= $signed(lower_q)))
		else $error("low trip disagrees with compare");
	a_hyst_follows: assert property (high_trip_out |-> hysteresis_trip_out)
		else $error("combined trip low while high trip set");
	a_hyst_hold: assert property (ce && !convert_trigger_done |=> $stable(hysteresis_trip_out))
		else $error("combined trip moved without conversion");
	a_pin_start: assert property (ce && !pe_s && clk_fall && cs_q == ttc_pkg::C_IDLE |=> convert_trigger_busy)
		else $error("falling convert pin did not start");
	a_lsb_out: assert property (ce && pe_s && clk_fall && st_q == ttc_pkg::S_READ |=> data_pin_drive == $past(sh_q[0]) && !data_pin_oe_n)
		else $error("read bit not driven in order");
	a_zero_tail: assert property (ce && pe_s && clk_fall && st_q == ttc_pkg::S_READ |=> sh_q[8] == 1'b0)
		else $error("shifter not zero filled");
	a_temp_range: assert property (temp_q == ttc_pkg::TEMP_POR || ($signed(temp_q) >= $signed(ttc_pkg::TEMP_MIN) && $signed(temp_q) <= $signed(ttc_pkg::TEMP_MAX)))
		else $error("temperature out of range");
	a_por_temp: assert property ($past(rst) |-> temp_q == ttc_pkg::TEMP_POR)
		else $error("temperature reset code wrong");
	a_trip_keep: assert property (ce && !commit |=> $stable(upper_q) && $stable(lower_q))
		else $error("trip point changed without write");
	a_convert_trigger_bound: assert property (convert_trigger_busy |-> cnt_q < CONVERT_TRIGGER_CYC[27:0])
		else $error("conversion overran its time");
	a_rise_release: assert property (ce && clk_rise |=> data_pin_oe_n)
		else $error("data still driven after rising edge");
	a_port_release: assert property (ce && !pe_s |=> data_pin_oe_n && st_q == ttc_pkg::S_CMD)
		else $error("closed port still drives data");

	c_convert_trigger_done: cover property (convert_trigger_done);
	c_read_bit: cover property (clk_fall && st_q == ttc_pkg::S_READ);
	c_write_commit: cover property (commit);
	c_hyst_rise: cover property ($rose(hysteresis_trip_out));

endmodule : ttc_core
`default_nettype wire

// ### logic/ttc_pkg.sv
/*
 * Shared constants of the thermometer/thermostat core: word layout,
 * reset values, command codes of the serial port and conversion timing.
 * Assumes a 200 MHz system clock.
 */
`default_nettype none
package ttc_pkg;
	// Word layout
	localparam int TEMP_W = 9; // Half-degree LSB, two's complement
	localparam int CMD_W = 8;
	localparam int BCNT_W = 5;
	localparam logic [4:0] BCNT_MAX = 5'h1f;
	// Reset values
	localparam logic [8:0] TEMP_POR = 9'h188; // -60 degrees
	localparam logic [8:0] LOWER_FACTORY = 9'h014; // +10 degrees
	localparam logic [8:0] UPPER_FACTORY = 9'h050; // +40 degrees
	// Measurable range
	localparam logic [8:0] TEMP_MIN = 9'h192; // -55 degrees
	localparam logic [8:0] TEMP_MAX = 9'h0fa; // +125 degrees
	// Command codes of the serial port
	localparam logic [7:0] CMD_RD_TEMP = 8'ha1;
	localparam logic [7:0] CMD_RD_UPPER = 8'ha2;
	localparam logic [7:0] CMD_RD_LOWER = 8'ha3;
	localparam logic [7:0] CMD_WR_UPPER = 8'h02;
	localparam logic [7:0] CMD_WR_LOWER = 8'h03;
	localparam logic [7:0] CMD_CONVERT = 8'hee;
	// Conversion timing
	localparam int CLK_MHZ = 200;
	localparam int CONVERT_TRIGGER_TIME_MS = 750;
	localparam int CONVERT_TRIGGER_CYCLES = CONVERT_TRIGGER_TIME_MS * CLK_MHZ * 1000;
	localparam int CONVERT_TRIGGER_CNT_W = 28;
	// Serial port states
	typedef enum logic [1:0] {S_CMD, S_READ, S_WRITE, S_IGNORE} ttc_port_t;
	// Conversion states
	typedef enum logic {C_IDLE, C_BUSY} ttc_convert_trigger_t;
endpackage : ttc_pkg
`default_nettype wire

// ### testbench/ttc_host.sv
/*
 * Host controller model for the 3-wire port of the thermometer core.
 * Assumes a 200 MHz clk_sys. One bit period is 160 ns (32 cycles).
 */
`timescale 1ns/1ps
`default_nettype none
module ttc_host (
	input wire logic clk_sys,
	output logic clock_convert_pin,
	output logic port_reset_pin,
	output logic host_bit,
	output logic host_oe,
	input wire logic wire_level
);
	// Half a bit period in system cycles
	localparam int HALF = 16;
	////////////////////////////////////////////////////////////////
	// Idle: clock high, so no stand-alone conversion starts
	initial
	begin
		clock_convert_pin = 1'b1;
		port_reset_pin = 1'b0;
		host_bit = 1'b0;
		host_oe = 1'b0;
	end
	// Wait n edges, then move just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	// One clock cycle: fall, then rise; wire is taken at the rise
	task automatic bit_cyc(input logic wr, input logic b, output logic got);
		clock_convert_pin = 1'b0;
		host_oe = wr;
		host_bit = b;
		tick(HALF);
		got = wire_level;
		clock_convert_pin = 1'b1;
		tick(HALF);
	endtask : bit_cyc
	// Whole transfer: command, nw bits written, nr bits read
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata, input int nw, input int nr,
		output logic [15:0] rdata);
		logic g;
		rdata = 16'h0000;
		port_reset_pin = 1'b1;
		tick(HALF);
		for (int i = 0; i < 8; i++)
			bit_cyc(1'b1, cmd[i], g);
		for (int i = 0; i < nw; i++)
			bit_cyc(1'b1, wdata[i], g);
		for (int i = 0; i < nr; i++)
		begin
			bit_cyc(1'b0, 1'b0, g);
			rdata[i] = g;
		end
		// Close only with the clock high, so no conversion fires
		host_oe = 1'b0;
		port_reset_pin = 1'b0;
		tick(2 * HALF);
	endtask : xfer
	// Stand-alone trigger: one low pulse with the port closed
	task automatic pulse_convert();
		clock_convert_pin = 1'b0;
		tick(HALF);
		clock_convert_pin = 1'b1;
		tick(HALF);
	endtask : pulse_convert
endmodule : ttc_host
`default_nettype wire

// ### testbench/tb_thermometer_thermostat_core.sv
/*
 * Testbench of the thermometer core: reset values, trip point access
 * and a table of conversions. Assumes the ttc_host model.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_thermometer_thermostat_core;
	// Short conversion keeps the run small
	localparam int CONVERT_TRIGGER = 40;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce_en = 1'b1;
	logic clock_convert_pin;
	logic port_reset_pin;
	logic host_bit;
	logic host_oe;
	logic wire_lvl;
	logic last_lvl = 1'b0;
	logic data_pin_drive;
	logic data_pin_oe_n;
	logic [8:0] sensor_code = 9'h000;
	logic high_trip_out;
	logic low_trip_out;
	logic hysteresis_trip_out;
	logic convert_trigger_busy;
	int mismatches = 0;
	int total_checks = 0;
	// Expected trip points and combined trip
	logic [8:0] ep_hi;
	logic [8:0] ep_lo;
	logic exp_hyst = 1'b0;
	logic [8:0] tbl [6] = '{9'h032, 9'h000, 9'h1ce, 9'h1cd, 9'h100, 9'h0fb};
	////////////////////////////////////////////////////////////////
	always #2.5 clk_sys = ~clk_sys;
	// Floating wire toggles, so a stale level never passes
	assign wire_lvl = (data_pin_oe_n === 1'b0) ? data_pin_drive : (host_oe ? host_bit : ~last_lvl);
	always @(posedge clk_sys) last_lvl <= wire_lvl;
	ttc_host host (.clk_sys(clk_sys), .clock_convert_pin(clock_convert_pin), .port_reset_pin(port_reset_pin),
		.host_bit(host_bit), .host_oe(host_oe), .wire_level(wire_lvl));
	ttc_core #(.CONVERT_TRIGGER_CYC(CONVERT_TRIGGER)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce_en),
		.clock_convert_pin(clock_convert_pin), .port_reset_pin(port_reset_pin), .data_pin_sample(wire_lvl),
		.data_pin_drive(data_pin_drive), .data_pin_oe_n(data_pin_oe_n), .sensor_code(sensor_code),
		.high_trip_out(high_trip_out), .low_trip_out(low_trip_out),
		.hysteresis_trip_out(hysteresis_trip_out), .convert_trigger_busy(convert_trigger_busy));
	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	// One conversion, by command or by pin pulse, then all checks
	task automatic convert(input logic [8:0] s, input logic by_cmd);
		logic [15:0] v;
		logic [8:0] t;
		int n;
		sensor_code = s;
		if (by_cmd)
			host.xfer(ttc_pkg::CMD_CONVERT, 16'h0000, 0, 0, v);
		else
			host.pulse_convert();
		n = 0;
		while (convert_trigger_busy !== 1'b0 && n < CONVERT_TRIGGER + 20)
		begin
			host.tick(1);
			n++;
		end
		check({15'h0, convert_trigger_busy}, 16'h0000);
		// Reading is clamped to the measurable range
		t = s;
		if ($signed(s) < $signed(ttc_pkg::TEMP_MIN))
			t = ttc_pkg::TEMP_MIN;
		else if ($signed(s) > $signed(ttc_pkg::TEMP_MAX))
			t = ttc_pkg::TEMP_MAX;
		if ($signed(t) >= $signed(ep_hi))
			exp_hyst = 1'b1;
		else if ($signed(t) < $signed(ep_lo))
			exp_hyst = 1'b0;
		check({13'h0, high_trip_out, low_trip_out, hysteresis_trip_out},
			{13'h0, $signed(t) >= $signed(ep_hi), $signed(t) <= $signed(ep_lo), exp_hyst});
		host.xfer(ttc_pkg::CMD_RD_TEMP, 16'h0000, 0, 16, v);
		check(v, {7'h00, t});
	endtask : convert
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [15:0] v;
		repeat (4) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		host.tick(4);
		host.xfer(ttc_pkg::CMD_RD_TEMP, 16'h0000, 0, 9, v);
		check(v, 16'h0188);
		host.xfer(ttc_pkg::CMD_RD_LOWER, 16'h0000, 0, 9, v);
		check(v, 16'h0014);
		host.xfer(ttc_pkg::CMD_RD_UPPER, 16'h0000, 0, 16, v);
		check(v, {7'h00, ttc_pkg::UPPER_FACTORY});
		$display("Test reset values done");
		// Nine-bit write, then a sixteen-bit one with junk on top
		ep_hi = 9'h032;
		ep_lo = 9'h1ce;
		host.xfer(ttc_pkg::CMD_WR_UPPER, 16'h0032, 9, 0, v);
		host.xfer(ttc_pkg::CMD_WR_LOWER, 16'hfbce, 16, 0, v);
		host.xfer(ttc_pkg::CMD_RD_UPPER, 16'h0000, 0, 16, v);
		check(v, 16'h0032);
		host.xfer(ttc_pkg::CMD_RD_LOWER, 16'h0000, 0, 16, v);
		check(v, 16'h01ce);
		check({15'h0, data_pin_oe_n}, 16'h0001);
		$display("Test trip point access done");
		// Frozen core must miss a convert pulse entirely
		ce_en = 1'b0;
		host.pulse_convert();
		host.tick(4);
		check({15'h0, convert_trigger_busy}, 16'h0000);
		ce_en = 1'b1;
		host.tick(8);
		check({15'h0, convert_trigger_busy}, 16'h0000);
		$display("Test clock enable done");
		for (int i = 0; i < 6; i++)
			convert(tbl[i], i[0]);
		$display("Test conversions done");
		stop_test();
	end
	// Watchdog well past the expected run length
	initial
	begin
		#200000;
		mismatches++;
		stop_test();
	end
endmodule : tb_thermometer_thermostat_core
`default_nettype wire
